// [hdl/parallel_config_load_port_defines.svh]
`ifndef PARALLEL_CONFIG_LOAD_PORT_DEFINES_SVH
`define PARALLEL_CONFIG_LOAD_PORT_DEFINES_SVH

// ----------------------------------------
// Width codes seen on the low byte lane
// ----------------------------------------
`define WIDTH_CODE_X8 8'h01
`define WIDTH_CODE_X16 8'h02
`define WIDTH_CODE_X32 8'h04

// ----------------------------------------
// Stream words
// ----------------------------------------
`define SYNC_WORD 32'h5a3c_c35a
`define STARTUP_CMD 32'h0d0e_0000
`define STARTUP_CMD_MASK 32'hffff_fff8
`define DONE_PHASE_LSB 0
`define DONE_PHASE_MSB 2
`define ABORT_STATUS 32'h0000_009f

// ----------------------------------------
// Counts
// ----------------------------------------
`define STARTUP_LAST 3'h7
`define ITEMS_LAST_X8 2'h3
`define ITEMS_LAST_X16 2'h1
`define ITEMS_LAST_X32 2'h0

`endif

// [hdl/parallel_config_load_port_pkg.sv]
package parallel_config_load_port_pkg;

    typedef enum logic [1:0] {
        BW_8 = 2'b00,
        BW_16 = 2'b01,
        BW_32 = 2'b10
    } busWidth_t;

    typedef enum logic [2:0] {
        ST_WIDTH = 3'b000,
        ST_SYNC = 3'b001,
        ST_LOAD = 3'b010,
        ST_STARTUP = 3'b011,
        ST_CONFIGURED = 3'b100
    } loadState_t;

endpackage

// [hdl/parallel_config_load_port.sv]
`include "parallel_config_load_port_defines.svh"

// Function
// - Chip select high: port ignored, data and busy pins released, direction ignored.
// - Direction low makes data pins inputs; high makes them outputs.
// - Direction rising while selected aborts; data pins then show abort status.
// - Direction falling while selected aborts; pins return to inputs, no status.
// - Selected in read direction, data pins are driven whatever the clock does.
// - Write samples data on rising config clock; read updates data on rising edges.
// - Busy never high in configuration; in readback low means valid data.
// - Busy released whenever chip select is deasserted, until reasserted.
// - Selecting with write direction drives busy low without a clock edge.
// - Only low byte sampled until width known, then full width for sync search.
// - Configuration processing starts only after the sync word is clocked in.
// - First item loads on first rising edge after select, then one per edge.
// - After startup command, startup runs eight cycles; done rises at chosen phase.
// - After configuration the port takes no items; direction toggles cause no abort.
// - Items on edges while deselected are discarded, pausing the load.
// - Byte mode: byte MSB on pin 0, LSB on pin 7, one per clock.
// - Data bus may be 8, 16 or 32 bits wide.
module parallel_config_load_port (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic chipSelect_n,
    input wire logic direction_read_n_write,
    input wire logic config_clock,
    input wire logic [31:0] dataIn,
    input wire logic [31:0] readbackWord,
    input wire logic readbackValid,
    output logic [31:0] dataOut,
    output logic [31:0] dataOe,
    output logic busyOut,
    output logic busyOe,
    output logic [31:0] configWord,
    output logic configWordValid,
    output logic configDone,
    output logic abortPulse
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic cclkS1_r;
    logic cclkS2_r;
    logic cclkS3_r;
    logic csS1_r;
    logic csS2_r;
    logic dirS1_r;
    logic dirS2_r;
    logic [31:0] dataS1_r;
    logic [31:0] dataS2_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cclkS1_r <= 1'b0;
            cclkS2_r <= 1'b0;
            cclkS3_r <= 1'b0;
            csS1_r <= 1'b1;
            csS2_r <= 1'b1;
            dirS1_r <= 1'b0;
            dirS2_r <= 1'b0;
            dataS1_r <= 32'h0000_0000;
            dataS2_r <= 32'h0000_0000;
        end else begin
            cclkS1_r <= config_clock;
            cclkS2_r <= cclkS1_r;
            cclkS3_r <= cclkS2_r;
            csS1_r <= chipSelect_n;
            csS2_r <= csS1_r;
            dirS1_r <= direction_read_n_write;
            dirS2_r <= dirS1_r;
            dataS1_r <= dataIn;
            dataS2_r <= dataS1_r;
        end
    end

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    parallel_config_load_port_pkg::loadState_t state_r;
    parallel_config_load_port_pkg::busWidth_t width_r;
    logic [31:0] acc_r;
    logic [1:0] itemCnt_r;
    logic [2:0] stepCnt_r;
    logic [2:0] donePhase_r;
    logic dirPrev_r;
    logic abortShow_r;
    logic rbValid_r;

    wire cclkRise = cclkS2_r & ~cclkS3_r;
    wire selected = ~csS2_r;
    wire readDir = dirS2_r;
    wire isConfigured = (state_r == parallel_config_load_port_pkg::ST_CONFIGURED);
    wire inStartup = (state_r == parallel_config_load_port_pkg::ST_STARTUP);
    // Direction held while deselected, so selecting in a changed direction aborts
    wire abortEvt = selected & ~isConfigured & (dirS2_r != dirPrev_r);
    wire item = selected & ~readDir & cclkRise & ~isConfigured & ~inStartup;

    // Per-lane bit reversal, pin 8*lane holds the byte MSB
    logic [31:0] swIn;
    logic [31:0] swOut;
    wire [31:0] rbSource = abortShow_r ? `ABORT_STATUS : readbackWord;
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_lane
            assign swIn[gi] = dataS2_r[(gi / 8) * 8 + 7 - (gi % 8)];
            assign swOut[(gi / 8) * 8 + 7 - (gi % 8)] = rbSource[gi];
        end
    endgenerate

    wire [31:0] acc8 = {acc_r[23:0], swIn[7:0]};
    wire [31:0] acc16 = {acc_r[15:0], swIn[7:0], swIn[15:8]};
    wire [31:0] acc32 = {swIn[7:0], swIn[15:8], swIn[23:16], swIn[31:24]};
    wire [31:0] accNxt = (width_r == parallel_config_load_port_pkg::BW_32) ? acc32 :
                         (width_r == parallel_config_load_port_pkg::BW_16) ? acc16 : acc8;
    wire [1:0] itemsLast = (width_r == parallel_config_load_port_pkg::BW_32) ? `ITEMS_LAST_X32 :
                           (width_r == parallel_config_load_port_pkg::BW_16) ? `ITEMS_LAST_X16 : `ITEMS_LAST_X8;
    wire wordDone = item & (state_r == parallel_config_load_port_pkg::ST_LOAD) & (itemCnt_r == itemsLast);
    wire startupHit = wordDone & ((accNxt & `STARTUP_CMD_MASK) == `STARTUP_CMD);
    wire [7:0] lowByte = swIn[7:0];
    wire widthHit = (lowByte == `WIDTH_CODE_X8) | (lowByte == `WIDTH_CODE_X16) | (lowByte == `WIDTH_CODE_X32);
    wire stepEdge = inStartup & cclkRise;

    // ----------------------------------------
    // Loader state machine
    // ----------------------------------------
    // Without a config clock edge only an abort changes state: a stopped clock pauses loading
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= parallel_config_load_port_pkg::ST_WIDTH;
            width_r <= parallel_config_load_port_pkg::BW_8;
            acc_r <= 32'h0000_0000;
            itemCnt_r <= 2'h0;
        end else if (abortEvt) begin
            state_r <= parallel_config_load_port_pkg::ST_WIDTH;
            width_r <= parallel_config_load_port_pkg::BW_8;
            acc_r <= 32'h0000_0000;
            itemCnt_r <= 2'h0;
        end else if (item) begin
            case (state_r)
                parallel_config_load_port_pkg::ST_WIDTH: begin
                    if (widthHit) begin
                        state_r <= parallel_config_load_port_pkg::ST_SYNC;
                        if (lowByte == `WIDTH_CODE_X32) begin
                            width_r <= parallel_config_load_port_pkg::BW_32;
                        end else if (lowByte == `WIDTH_CODE_X16) begin
                            width_r <= parallel_config_load_port_pkg::BW_16;
                        end else begin
                            width_r <= parallel_config_load_port_pkg::BW_8;
                        end
                    end
                end
                parallel_config_load_port_pkg::ST_SYNC: begin
                    acc_r <= accNxt;
                    if (accNxt == `SYNC_WORD) begin
                        state_r <= parallel_config_load_port_pkg::ST_LOAD;
                        itemCnt_r <= 2'h0;
                    end
                end
                parallel_config_load_port_pkg::ST_LOAD: begin
                    acc_r <= accNxt;
                    itemCnt_r <= wordDone ? 2'h0 : itemCnt_r + 2'h1;
                    if (startupHit) begin
                        state_r <= parallel_config_load_port_pkg::ST_STARTUP;
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end else if (stepEdge && stepCnt_r == `STARTUP_LAST) begin
            state_r <= parallel_config_load_port_pkg::ST_CONFIGURED;
        end
    end

    // ----------------------------------------
    // Startup sequence and done
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stepCnt_r <= 3'h0;
            donePhase_r <= 3'h0;
            configDone <= 1'b0;
        end else if (startupHit && !abortEvt) begin
            stepCnt_r <= 3'h0;
            donePhase_r <= accNxt[`DONE_PHASE_MSB:`DONE_PHASE_LSB];
        end else if (stepEdge) begin
            stepCnt_r <= stepCnt_r + 3'h1;
            if (stepCnt_r == donePhase_r) begin
                configDone <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Stream words and abort strobe
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            configWord <= 32'h0000_0000;
            configWordValid <= 1'b0;
            abortPulse <= 1'b0;
        end else begin
            configWordValid <= wordDone & ~abortEvt;
            if (wordDone) begin
                configWord <= accNxt;
            end
            abortPulse <= abortEvt;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dirPrev_r <= 1'b0;
            abortShow_r <= 1'b0;
        end else begin
            if (selected) begin
                dirPrev_r <= dirS2_r;
            end
            if (abortEvt) begin
                abortShow_r <= readDir;
            end else if (!selected) begin
                abortShow_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dataOe <= 32'h0000_0000;
            busyOe <= 1'b0;
        end else begin
            dataOe <= {32{selected & readDir}};
            busyOe <= selected;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dataOut <= 32'h0000_0000;
            rbValid_r <= 1'b0;
            busyOut <= 1'b0;
        end else begin
            if (selected && readDir && cclkRise) begin
                dataOut <= swOut;
                rbValid_r <= abortShow_r | readbackValid;
            end else if (!(selected && readDir)) begin
                rbValid_r <= 1'b0;
            end
            busyOut <= selected & readDir & ~rbValid_r;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    chk_deselect_quiet: assert property (!selected |=> (dataOe == 32'h0000_0000) && !busyOe)
        else $error("pins driven while deselected");
    chk_read_drives: assert property (selected && readDir |=> dataOe == 32'hffff_ffff)
        else $error("read direction not driving data");
    chk_abort_up: assert property (abortEvt && readDir |=> abortShow_r && abortPulse)
        else $error("rising abort lost");
    chk_abort_down: assert property (abortEvt && !readDir |=> !abortShow_r ##1 dataOe == 32'h0000_0000)
        else $error("falling abort kept status");
    chk_busy_write: assert property (selected && !readDir |=> busyOe && !busyOut)
        else $error("busy not low in write");
    chk_discard_deselected: assert property (cclkRise && !selected |=> $stable(acc_r) && !configWordValid)
        else $error("deselected item taken");
    chk_startup_min: assert property (stepEdge && stepCnt_r != `STARTUP_LAST && !abortEvt |=> inStartup)
        else $error("startup shorter than eight cycles");
    chk_done_before_end: assert property ($rose(isConfigured) |-> configDone)
        else $error("configured without done");
    chk_no_late_abort: assert property (isConfigured |=> isConfigured && !abortPulse)
        else $error("abort after configuration");
    chk_sync_gate: assert property (configWordValid |-> $past(state_r) == parallel_config_load_port_pkg::ST_LOAD)
        else $error("word before sync");
    chk_read_update: assert property (!cclkRise |=> $stable(dataOut))
        else $error("readback data moved off edge");

    cov_sync_found: cover property (state_r == parallel_config_load_port_pkg::ST_SYNC
        ##1 state_r == parallel_config_load_port_pkg::ST_LOAD);
    cov_configured: cover property ($rose(isConfigured));
    cov_abort_read: cover property (abortEvt && readDir);

endmodule

// [bench/config_host_model.sv]
module config_host_model (
    input wire logic clock,
    output logic chipSelect_n,
    output logic direction_read_n_write,
    output logic config_clock,
    output logic [31:0] dataIn
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chipSelect_n = 1'b1;
        direction_read_n_write = 1'b0;
        config_clock = 1'b0;
        dataIn = 32'h0000_0000;
    end

    // ----------------------------------------
    // Pin ordering
    // ----------------------------------------
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = b[7 - i];
        end
    endfunction

    function automatic logic [31:0] pack32(input logic [31:0] w);
        for (int k = 0; k < 4; k++) begin
            pack32[8 * k +: 8] = rev8(w[31 - 8 * k -: 8]);
        end
    endfunction

    // Readback keeps each byte in its own lane, bits reversed
    function automatic logic [31:0] rev_lanes(input logic [31:0] w);
        for (int k = 0; k < 4; k++) begin
            rev_lanes[8 * k +: 8] = rev8(w[8 * k +: 8]);
        end
    endfunction

    // ----------------------------------------
    // Pin actions
    // ----------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Direction is already low when selecting
    task automatic select_port();
        chipSelect_n <= 1'b0;
        wait_clk(8);
    endtask

    // Released bus shows the inverse, not the last value
    task automatic deselect_port();
        chipSelect_n <= 1'b1;
        dataIn <= ~dataIn;
        wait_clk(8);
    endtask

    task automatic set_dir(input logic d);
        direction_read_n_write <= d;
        if (d) begin
            dataIn <= ~dataIn;
        end
        wait_clk(8);
    endtask

    // Clock stands low outside items; stopping it pauses the load
    task automatic tick();
        config_clock <= 1'b1;
        wait_clk(4);
        config_clock <= 1'b0;
        wait_clk(4);
    endtask

    task automatic send_pins(input logic [31:0] p);
        dataIn <= p;
        wait_clk(4);
        tick();
    endtask

    task automatic send_byte(input logic [7:0] b);
        send_pins({24'h00_0000, rev8(b)});
    endtask

    // Upper byte of the half on lane 0
    task automatic send_half16(input logic [15:0] h);
        send_pins({16'h0000, rev8(h[7:0]), rev8(h[15:8])});
    endtask

    task automatic send_word32(input logic [31:0] w);
        send_pins(pack32(w));
    endtask
endmodule

// [bench/parallel_config_load_port_tb_top.sv]
`include "parallel_config_load_port_defines.svh"

module parallel_config_load_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, sys_rst, readbackValid, chipSelect_n, direction_read_n_write, config_clock;
    logic [31:0] readbackWord, dataIn, dataOut, dataOe, configWord;
    logic busyOut, busyOe, configWordValid, configDone, abortPulse;
    int n_fail, samples_checked, nAbort;
    logic [31:0] words[$];

    parallel_config_load_port parallel_config_load_port_inst (
        .clock(clock), .sys_rst(sys_rst), .chipSelect_n(chipSelect_n),
        .direction_read_n_write(direction_read_n_write), .config_clock(config_clock),
        .dataIn(dataIn), .readbackWord(readbackWord), .readbackValid(readbackValid),
        .dataOut(dataOut), .dataOe(dataOe), .busyOut(busyOut), .busyOe(busyOe),
        .configWord(configWord), .configWordValid(configWordValid),
        .configDone(configDone), .abortPulse(abortPulse)
    );

    config_host_model config_host_model_inst (
        .clock(clock), .chipSelect_n(chipSelect_n),
        .direction_read_n_write(direction_read_n_write),
        .config_clock(config_clock), .dataIn(dataIn)
    );

    // ----------------------------------------
    // Clock, monitor, checks
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock) begin
        if (configWordValid === 1'b1) begin
            words.push_back(configWord);
        end
        if (abortPulse === 1'b1) begin
            nAbort++;
        end
    end

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_flag(input string name, input logic exp, input logic got);
        check_val(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset_values();
        #1;
        check_flag("configDone", 1'b0, configDone);
        check_flag("busyOe", 1'b0, busyOe);
        check_val("dataOe", 32'h0000_0000, dataOe);
        @(posedge clock);
    endtask

    task automatic test_x8_paused_load();
        logic [31:0] sw;
        sw = `SYNC_WORD;
        config_host_model_inst.select_port();
        check_flag("busyOe", 1'b1, busyOe);
        check_flag("busyOut", 1'b0, busyOut);
        check_val("dataOe", 32'h0000_0000, dataOe);
        config_host_model_inst.send_byte(`WIDTH_CODE_X8);
        config_host_model_inst.send_byte(8'h77);
        for (int i = 0; i < 4; i++) begin
            config_host_model_inst.send_byte(sw[31 - 8 * i -: 8]);
        end
        words.delete();
        config_host_model_inst.send_byte(8'ha1);
        config_host_model_inst.deselect_port();
        config_host_model_inst.send_byte(8'hff);
        config_host_model_inst.select_port();
        config_host_model_inst.send_byte(8'hb2);
        config_host_model_inst.wait_clk(40);
        config_host_model_inst.send_byte(8'hc3);
        config_host_model_inst.send_byte(8'hd4);
        check_val("wordCount", 32'h1, 32'(words.size()));
        check_val("configWord", 32'ha1b2_c3d4, words[0]);
        check_val("abortCount", 32'h0, 32'(nAbort));
    endtask

    task automatic test_read_abort();
        config_host_model_inst.set_dir(1'b1);
        check_val("abortCount", 32'h1, 32'(nAbort));
        check_val("dataOe", 32'hffff_ffff, dataOe);
        config_host_model_inst.tick();
        check_val("dataOut", config_host_model_inst.rev_lanes(`ABORT_STATUS), dataOut);
        check_flag("busyOut", 1'b0, busyOut);
        config_host_model_inst.set_dir(1'b0);
        check_val("abortCount", 32'h2, 32'(nAbort));
        check_val("dataOe", 32'h0000_0000, dataOe);
        check_flag("busyOut", 1'b0, busyOut);
        config_host_model_inst.deselect_port();
        check_flag("busyOe", 1'b0, busyOe);
        check_val("dataOe", 32'h0000_0000, dataOe);
        config_host_model_inst.set_dir(1'b1);
        config_host_model_inst.set_dir(1'b0);
        check_val("abortCount", 32'h2, 32'(nAbort));
    endtask

    task automatic test_x32_startup();
        config_host_model_inst.select_port();
        config_host_model_inst.send_word32({`WIDTH_CODE_X32, 24'hff_ffff});
        config_host_model_inst.send_word32(`SYNC_WORD);
        words.delete();
        config_host_model_inst.send_word32(32'h1234_5678);
        config_host_model_inst.send_word32(`STARTUP_CMD | 32'h0000_0002);
        check_val("configWord", 32'h1234_5678, words[0]);
        config_host_model_inst.tick();
        config_host_model_inst.tick();
        check_flag("configDone", 1'b0, configDone);
        config_host_model_inst.tick();
        check_flag("configDone", 1'b1, configDone);
        repeat (5) config_host_model_inst.tick();
        readbackWord <= 32'h8421_c3a5;
        readbackValid <= 1'b1;
        config_host_model_inst.set_dir(1'b1);
        config_host_model_inst.tick();
        check_val("dataOut", config_host_model_inst.rev_lanes(32'h8421_c3a5), dataOut);
        check_flag("busyOut", 1'b0, busyOut);
        readbackValid <= 1'b0;
        config_host_model_inst.tick();
        check_flag("busyOut", 1'b1, busyOut);
        config_host_model_inst.set_dir(1'b0);
        check_val("abortCount", 32'h2, 32'(nAbort));
        check_flag("configDone", 1'b1, configDone);
    endtask

    task automatic test_x16_after_reset();
        logic [31:0] sw;
        sw = `SYNC_WORD;
        config_host_model_inst.deselect_port();
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        test_reset_values();
        config_host_model_inst.select_port();
        config_host_model_inst.send_half16({`WIDTH_CODE_X16, 8'hff});
        config_host_model_inst.send_half16(sw[31:16]);
        config_host_model_inst.send_half16(sw[15:0]);
        words.delete();
        config_host_model_inst.send_half16(16'hcafe);
        config_host_model_inst.send_half16(16'hf00d);
        check_val("wordCount", 32'h1, 32'(words.size()));
        check_val("configWord", 32'hcafe_f00d, words[0]);
        check_val("abortCount", 32'h2, 32'(nAbort));
    endtask

    initial begin
        sys_rst = 1'b1;
        readbackWord = 32'h0000_0000;
        readbackValid = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        nAbort = 0;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        test_reset_values();
        test_x8_paused_load();
        test_read_abort();
        test_x32_startup();
        test_x16_after_reset();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        report_and_stop();
    end
endmodule
